// file: rtl/spf_pkg.sv
/*
  Shared types and constants of the serial port with data packing.
  Assumes one 100 MHz clock, synchronous inputs, configuration held stable.
*/
// Functional notes
// - bit rate set by a clock divisor, covering 110 to 460800 bit/s
// - parity none: no parity bit sent, none checked on receive
// - odd parity: ones across data and parity come to an odd count
// - even parity: ones across data and parity come to an even count
// - mark parity: parity slot always sent as 1
// - space parity: parity slot always sent as 0
// - five to eight data bits per character
// - one, one and a half or two stop bits; 1.5 lasts 150% bit time
// - both line ends must use the same stop bit count
// - software flow: send XOFF to pause the sender; stop sending on XOFF
// - software flow: send XON when ready again; resume sending on XON
// - hardware flow: send only while clear-to-send; signal own readiness
// - hardware flow selectable as RTS/CTS or DTR/DSR pair
// - line interface RS-232, RS-422, two-wire or four-wire RS-485
// - performance: throughput packing or latency forwarding per byte
// - up to four delimiter bytes per direction, any value
// - received data held until all delimiters match or another flush
// - packet forwarded when 4K bytes collected
// - serial-to-network flush timeout 0..65535 s, 0 disables
// - forced transmit interval or full 4K buffer sends queued data

package spf_pkg;
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned BAUD_MIN  = 110;
  localparam int unsigned BAUD_MAX  = 460_800;
  localparam int unsigned DIV_MIN   = CLK_HZ / BAUD_MAX;
  localparam int unsigned DIV_MAX   = CLK_HZ / BAUD_MIN;
  localparam int          DIV_W     = 20;       // holds DIV_MAX
  localparam int unsigned BUF_BYTES = 4096;
  localparam int unsigned TMR_UNIT_S = 1;       // timeout unit, seconds
  localparam int unsigned SEC_CYC   = CLK_HZ * TMR_UNIT_S;
  localparam logic [7:0]  XON_CHAR  = 8'h11;
  localparam logic [7:0]  XOFF_CHAR = 8'h13;
  localparam logic        TXD_IDLE  = 1'b1;

  typedef enum logic [2:0] {
    PAR_NONE = 3'h0, PAR_ODD = 3'h1, PAR_EVEN = 3'h2,
    PAR_MARK = 3'h3, PAR_SPACE = 3'h4
  } spf_par_t;
  typedef enum logic [1:0] {STOP_1 = 2'h0, STOP_1P5 = 2'h1, STOP_2 = 2'h2} spf_stop_t;
  typedef enum logic [1:0] {
    FLOW_NONE = 2'h0, FLOW_XON = 2'h1, FLOW_RTS = 2'h2, FLOW_DTR = 2'h3
  } spf_flow_t;
  typedef enum logic [1:0] {
    IFC_232 = 2'h0, IFC_422 = 2'h1, IFC_485_2W = 2'h2, IFC_485_4W = 2'h3
  } spf_ifc_t;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
  } spf_tx_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
  } spf_rx_t;

  typedef struct packed {
    logic [DIV_W-1:0] baud_div;   // clock cycles per bit
    spf_par_t         par;
    logic [1:0]       data_bits;  // 0..3 for 5..8 bits
    spf_stop_t        stop;
    spf_flow_t        flow;
    spf_ifc_t         ifc;
    logic             perf_lat;   // 1: latency, 0: throughput
  } spf_cfg_t;
  typedef struct packed {
    logic [3:0][7:0] val;
    logic [2:0]      cnt;         // 0..4 delimiters in use
  } spf_dlm_t;
  typedef struct packed {
    spf_dlm_t    s2n;
    spf_dlm_t    n2s;
    logic [15:0] flush_sec;
    logic [15:0] force_sec;
  } spf_pack_t;
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } spf_ent_t;
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic overrun;
    logic paused;
  } spf_stat_t;
endpackage : spf_pkg

// file: rtl/spf_serial_port.sv
/*
  Serial port framer with per-direction delimiter packing.
  Assumes synchronous rxd and flow inputs, configuration changed only when idle.
*/
`timescale 1ns/10ps
`default_nettype none

module spf_serial_port
  import spf_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC,
  parameter int unsigned PACK_BYTES = BUF_BYTES
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // configuration
  input  wire spf_cfg_t   cfg,
  input  wire spf_pack_t  pack,
  // serial line
  input  wire logic       rxd,
  output logic            txd,
  output logic            drv_en,
  output logic            rcv_en_n,
  output logic            rts_out,
  output logic            dtr_out,
  input  wire logic       cts_in,
  input  wire logic       dsr_in,
  // serial to network stream
  output logic            s2n_valid,
  input  wire logic       s2n_ready,
  output spf_ent_t        s2n_ent,
  // network to serial stream
  input  wire logic       n2s_valid,
  output logic            n2s_ready,
  input  wire logic [7:0] n2s_data,
  output logic            n2s_flush,
  // status
  output spf_stat_t       stat
);
  localparam int SC_W  = $clog2(SEC_CYCLES + 1);
  localparam int CNT_W = $clog2(PACK_BYTES + 1);

  typedef struct packed {
    spf_tx_t          tx_st;
    logic [DIV_W:0]   tx_cnt;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic [7:0]       tx_chr;
    logic             tx_line;
    spf_rx_t          rx_st;
    logic [DIV_W:0]   rx_cnt;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             rx_pbit;
    logic             xoff_sent;
    logic             fc_req;
    logic [7:0]       fc_chr;
    logic             hold_v;
    logic             hold_last;
    logic [7:0]       hold_d;
    logic [1:0]       s2n_pos;
    logic [CNT_W-1:0] s2n_cnt;
    logic [SC_W-1:0]  fl_cyc;
    logic [15:0]      fl_sec;
    spf_ent_t [1:0]   mem;
    logic             wr;
    logic             rd;
    logic [1:0]       b_n;
    logic [1:0]       n2s_pos;
    logic [CNT_W-1:0] n2s_cnt;
    logic [SC_W-1:0]  fo_cyc;
    logic [15:0]      fo_sec;
    logic             flush;
    spf_stat_t        stat;
  } spf_state_t;

  spf_state_t       r;
  spf_state_t       n;
  logic [DIV_W:0]   div1;
  logic [DIV_W:0]   stop_len;
  logic [2:0]       nb_last;
  logic [7:0]       dmask;
  logic             tx_ok;
  logic             rx_mute;
  logic             busy;
  logic             pop;

  // parity of the masked data for the chosen mode
  function automatic logic par_bit(spf_par_t p, logic [7:0] d, logic [7:0] m);
    logic [7:0] x;
    x = d & m;
    case (p)
      PAR_ODD:  par_bit = ~^x;
      PAR_EVEN: par_bit = ^x;
      PAR_MARK: par_bit = 1'b1;
      default:  par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // delimiter chain step: {hit, next position}; no delimiters ends each byte
  function automatic logic [2:0] dl_step(spf_dlm_t d, logic [1:0] pos, logic [7:0] b);
    logic [2:0] nx;
    nx = {1'b0, pos} + 3'h1;
    dl_step = 3'h0;
    if (b == d.val[pos]) begin
      dl_step = (nx == d.cnt) ? 3'h4 : {1'b0, nx[1:0]};
    end else if (b == d.val[0]) begin
      dl_step = (d.cnt == 3'h1) ? 3'h4 : 3'h1;
    end
    if (d.cnt == 3'h0) begin
      dl_step = 3'h4;
    end
  endfunction : dl_step

  // seconds timer step: {expired, seconds, cycles}; a zero limit disables
  function automatic logic [SC_W+16:0] tmr_step(logic [SC_W-1:0] c, logic [15:0] s,
                                                logic [15:0] lim, logic restart);
    logic [SC_W-1:0] cn;
    logic [15:0]     sn;
    logic            ex;
    cn = c + 1'b1;
    sn = s;
    ex = 1'b0;
    if (restart || lim == 16'h0000) begin
      cn = '0;
      sn = '0;
    end else if (c == SC_W'(SEC_CYCLES - 1)) begin
      cn = '0;
      sn = s + 16'h0001;
      if (sn == lim) begin
        ex = 1'b1;
        sn = '0;
      end
    end
    tmr_step = {ex, sn, cn};
  endfunction : tmr_step

  // character timing derived from configuration
  assign div1     = {1'b0, cfg.baud_div};
  assign nb_last  = {1'b0, cfg.data_bits} + 3'h4;
  assign dmask    = 8'hFF >> (2'h3 - cfg.data_bits);
  always_comb begin
    case (cfg.stop)
      STOP_1:   stop_len = div1;
      STOP_1P5: stop_len = div1 + {2'b00, cfg.baud_div[DIV_W-1:1]};
      default:  stop_len = {cfg.baud_div, 1'b0};
    endcase
  end

  // flow gating: the sender is held by the far end's XOFF or clear signal
  always_comb begin
    case (cfg.flow)
      FLOW_XON: tx_ok = !r.stat.paused;
      FLOW_RTS: tx_ok = cts_in;
      FLOW_DTR: tx_ok = dsr_in;
      default:  tx_ok = 1'b1;
    endcase
  end

  // any byte in the two-entry buffer asks the far end to pause; leaves slack for bytes in flight
  assign busy      = r.b_n != 2'h0;
  assign rts_out   = (cfg.flow == FLOW_RTS) ? !busy : 1'b1;
  assign dtr_out   = (cfg.flow == FLOW_DTR) ? !busy : 1'b1;
  assign n2s_ready = r.tx_st == TX_IDLE && !r.fc_req && tx_ok;
  assign s2n_valid = r.b_n != 2'h0;
  assign pop       = s2n_valid && s2n_ready;
  assign s2n_ent   = r.mem[r.rd];
  assign txd       = r.tx_line;
  assign n2s_flush = r.flush;
  assign stat      = r.stat;

  // 485 drivers only while a character is on the wire; two-wire mutes own echo
  assign drv_en   = (cfg.ifc == IFC_232 || cfg.ifc == IFC_422) || r.tx_st != TX_IDLE;
  assign rcv_en_n = cfg.ifc == IFC_485_2W && r.tx_st != TX_IDLE;
  assign rx_mute  = rcv_en_n;

  // next state of the whole port
  always_comb begin
    logic             ld;
    logic [7:0]       chr;
    logic             got;
    logic             push;
    logic [2:0]       dl;
    logic             last;
    logic [SC_W+16:0] tm;
    spf_ent_t         ent;
    n = r;
    ld = 1'b0;
    chr = 8'h00;
    got = 1'b0;
    push = 1'b0;
    dl = 3'h0;
    last = 1'b0;
    tm = '0;
    ent = '0;
    n.stat.parity_err = 1'b0;
    n.stat.frame_err = 1'b0;
    n.stat.overrun = 1'b0;
    n.flush = 1'b0;

    // transmitter: flow characters go ahead of data
    if (r.tx_cnt != '0) begin
      n.tx_cnt = r.tx_cnt - 1'b1;
    end else begin
      case (r.tx_st)
        TX_IDLE: begin
          n.tx_line = TXD_IDLE;
          if (r.fc_req) begin
            ld = 1'b1;
            chr = r.fc_chr;
            n.fc_req = 1'b0;
          end else if (n2s_valid && n2s_ready) begin
            ld = 1'b1;
            chr = n2s_data;
          end
          if (ld) begin
            n.tx_st = TX_START;
            n.tx_cnt = div1 - 1'b1;
            n.tx_chr = chr;
            n.tx_sh = chr;
            n.tx_line = 1'b0;
          end
        end
        TX_START: begin
          n.tx_st = TX_DATA;
          n.tx_cnt = div1 - 1'b1;
          n.tx_bit = 3'h0;
          n.tx_line = r.tx_sh[0];
          n.tx_sh = r.tx_sh >> 1;
        end
        TX_DATA: begin
          if (r.tx_bit == nb_last) begin
            if (cfg.par == PAR_NONE) begin
              n.tx_st = TX_STOP;
              n.tx_cnt = stop_len - 1'b1;
              n.tx_line = 1'b1;
            end else begin
              n.tx_st = TX_PAR;
              n.tx_cnt = div1 - 1'b1;
              n.tx_line = par_bit(cfg.par, r.tx_chr, dmask);
            end
          end else begin
            n.tx_bit = r.tx_bit + 3'h1;
            n.tx_cnt = div1 - 1'b1;
            n.tx_line = r.tx_sh[0];
            n.tx_sh = r.tx_sh >> 1;
          end
        end
        TX_PAR: begin
          n.tx_st = TX_STOP;
          n.tx_cnt = stop_len - 1'b1;
          n.tx_line = 1'b1;
        end
        default: begin
          n.tx_st = TX_IDLE;
        end
      endcase
    end

    // receiver: samples mid-bit, checks only the first stop bit
    if (r.rx_cnt != '0) begin
      n.rx_cnt = r.rx_cnt - 1'b1;
    end else begin
      case (r.rx_st)
        RX_IDLE: begin
          if (!rxd && !rx_mute) begin
            n.rx_st = RX_START;
            n.rx_cnt = {1'b0, cfg.baud_div >> 1};
          end
        end
        RX_START: begin
          n.rx_st = rxd ? RX_IDLE : RX_DATA; // glitch is not a start
          n.rx_cnt = div1 - 1'b1;
          n.rx_bit = 3'h0;
        end
        RX_DATA: begin
          n.rx_sh = {rxd, r.rx_sh[7:1]};
          n.rx_cnt = div1 - 1'b1;
          n.rx_bit = r.rx_bit + 3'h1;
          if (r.rx_bit == nb_last) begin
            n.rx_st = (cfg.par == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          n.rx_pbit = rxd;
          n.rx_st = RX_STOP;
          n.rx_cnt = div1 - 1'b1;
        end
        default: begin
          n.rx_st = RX_IDLE;
          chr = r.rx_sh >> (2'h3 - cfg.data_bits);
          if (!rxd) begin
            n.stat.frame_err = 1'b1;
          end else begin
            if (cfg.par != PAR_NONE && r.rx_pbit != par_bit(cfg.par, chr, dmask)) begin
              n.stat.parity_err = 1'b1;
            end
            if (cfg.flow == FLOW_XON && chr == XOFF_CHAR) begin
              n.stat.paused = 1'b1;
            end else if (cfg.flow == FLOW_XON && chr == XON_CHAR) begin
              n.stat.paused = 1'b0;
            end else begin
              got = 1'b1;
            end
          end
        end
      endcase
    end
    if (cfg.flow != FLOW_XON) begin
      n.stat.paused = 1'b0;
    end

    // own flow characters: XOFF once the buffer holds any byte, XON once drained
    if (cfg.flow != FLOW_XON) begin
      n.xoff_sent = 1'b0;
    end else if (!r.fc_req && busy && !r.xoff_sent) begin
      n.fc_req = 1'b1;
      n.fc_chr = XOFF_CHAR;
      n.xoff_sent = 1'b1;
    end else if (!r.fc_req && !busy && r.xoff_sent) begin
      n.fc_req = 1'b1;
      n.fc_chr = XON_CHAR;
      n.xoff_sent = 1'b0;
    end

    // packing: newest byte waits in hold until the next byte arrives or it is known to end a packet
    if (r.hold_v && (r.hold_last || got) && r.b_n != 2'h2) begin
      push = 1'b1;
      ent = '{last: r.hold_last, data: r.hold_d};
      n.hold_v = 1'b0;
    end
    if (got) begin
      dl = dl_step(pack.s2n, r.s2n_pos, chr);
      n.s2n_pos = dl[1:0];
      last = dl[2] || r.s2n_cnt == CNT_W'(PACK_BYTES - 1) || cfg.perf_lat;
      n.s2n_cnt = last ? '0 : r.s2n_cnt + 1'b1;
      if (n.hold_v) begin
        n.stat.overrun = 1'b1; // stalled buffer: byte lost
      end else begin
        n.hold_v = 1'b1;
        n.hold_last = last;
        n.hold_d = chr;
      end
    end
    tm = tmr_step(r.fl_cyc, r.fl_sec, pack.flush_sec, got || push);
    n.fl_cyc = tm[SC_W-1:0];
    n.fl_sec = tm[SC_W+15:SC_W];
    if (tm[SC_W+16] && n.hold_v) begin
      n.hold_last = 1'b1;
      n.s2n_cnt = '0;
      n.s2n_pos = 2'h0;
    end

    // two-entry buffer toward the network
    if (push) begin
      n.mem[r.wr] = ent;
      n.wr = ~r.wr;
    end
    if (pop) begin
      n.rd = ~r.rd;
    end
    n.b_n = r.b_n + {1'b0, push} - {1'b0, pop};

    // network-to-serial packing: ask upstream to send on any flush cause
    tm = tmr_step(r.fo_cyc, r.fo_sec, pack.force_sec, n2s_valid && n2s_ready);
    n.fo_cyc = tm[SC_W-1:0];
    n.fo_sec = tm[SC_W+15:SC_W];
    n.flush = tm[SC_W+16];
    if (n2s_valid && n2s_ready) begin
      dl = dl_step(pack.n2s, r.n2s_pos, n2s_data);
      n.n2s_pos = dl[1:0];
      last = dl[2] || r.n2s_cnt == CNT_W'(PACK_BYTES - 1);
      n.n2s_cnt = last ? '0 : r.n2s_cnt + 1'b1;
      n.flush = last;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r <= '0;
      r.tx_st <= TX_IDLE;
      r.rx_st <= RX_IDLE;
      r.tx_line <= TXD_IDLE;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_tx_go;
    r.tx_st == TX_IDLE ##1 r.tx_st == TX_START;
  endsequence
  sequence s_last_data;
    r.tx_st == TX_DATA && r.tx_cnt == '0 && r.tx_bit == nb_last;
  endsequence

  AST_START_LOW: assert property (s_tx_go |-> !txd && drv_en)
    else $error("start bit not driven low");
  AST_NO_PAR: assert property ((s_last_data and cfg.par == PAR_NONE) |=> r.tx_st == TX_STOP)
    else $error("parity slot sent with parity off");
  AST_ODD: assert property (r.tx_st == TX_PAR && cfg.par == PAR_ODD |-> ^{txd, r.tx_chr & dmask})
    else $error("odd parity wrong");
  AST_EVEN: assert property (r.tx_st == TX_PAR && cfg.par == PAR_EVEN |-> !(^{txd, r.tx_chr & dmask}))
    else $error("even parity wrong");
  AST_MARK: assert property (r.tx_st == TX_PAR && cfg.par == PAR_MARK |-> txd)
    else $error("mark parity not high");
  AST_SPACE: assert property (r.tx_st == TX_PAR && cfg.par == PAR_SPACE |-> !txd)
    else $error("space parity not low");
  AST_STOP_LEN: assert property ($rose(r.tx_st == TX_STOP) |-> txd && r.tx_cnt == stop_len - 1'b1)
    else $error("stop interval wrong");
  AST_XOFF_HOLD: assert property (cfg.flow == FLOW_XON && r.stat.paused |-> !n2s_ready)
    else $error("sending while paused");
  AST_CTS: assert property (cfg.flow == FLOW_RTS && !cts_in |-> !n2s_ready)
    else $error("sending without clear");
  AST_LAT: assert property (cfg.perf_lat && $rose(r.hold_v) |-> r.hold_last)
    else $error("latency mode held a byte");
  AST_FULL: assert property ($rose(r.hold_v) && $past(r.s2n_cnt) == CNT_W'(PACK_BYTES - 1)
                            |-> r.hold_last)
    else $error("full packet not ended");
  AST_485: assert property (cfg.ifc == IFC_485_2W && r.tx_st != TX_IDLE |-> drv_en && rcv_en_n)
    else $error("two-wire drive state wrong");
endmodule : spf_serial_port

`default_nettype wire

// file: sim/spf_far_dev.sv
/*
  far-end serial device: sends raw bit slots on rxd, samples txd frames.
  assumes one bit time of DIV sys_clk cycles on both line ends.
*/
`timescale 1ns/10ps
`default_nettype none

module spf_far_dev #(
  parameter int DIV = 217
) (
  // clock
  input  wire logic        sys_clk,
  // serial line
  input  wire logic        txd,
  output logic             rxd,
  // capture of the last frame seen on txd
  output logic [11:0]      cap_bits,
  output logic [7:0]       cap_cnt
);
  initial begin
    rxd = 1'b1;
    cap_bits = '1;
    cap_cnt = 8'h00;
  end

  // twelve slots lsb first; caller sets start, data, parity, stop count
  task automatic send_raw(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      rxd = f[i];
      repeat (DIV - 1) @(negedge sys_clk);
    end
    @(negedge sys_clk);
    rxd = 1'b1;
  endtask : send_raw

  // mid-bit sampling; slots past the frame read idle high
  always begin : rx_watch
    @(negedge txd);
    repeat (DIV / 2) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) begin
      cap_bits[i] = txd;
      if (i < 11) repeat (DIV) @(posedge sys_clk);
    end
    cap_cnt = cap_cnt + 8'h01;
  end
endmodule : spf_far_dev

`default_nettype wire

// file: sim/spf_serial_port_bench.sv
/*
  bench of the serial port: framing, packing, flow control and buffering.
  assumes spf_far_dev on the line side and one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module spf_serial_port_bench;
  import spf_pkg::*;
  localparam int DIV = 217;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  spf_cfg_t    cfg;
  spf_pack_t   pack;
  logic        rxd, txd, drv_en, rcv_en_n, rts_out, dtr_out;
  logic        cts_in = 1'b1;
  logic        dsr_in = 1'b1;
  logic        s2n_valid, n2s_ready, n2s_flush;
  logic        s2n_ready = 1'b1;
  logic        n2s_valid = 1'b0;
  logic [7:0]  n2s_data = 8'h00;
  spf_ent_t    s2n_ent;
  spf_stat_t   stat;
  logic [11:0] cap_bits, f;
  logic [7:0]  cap_cnt, c0;
  logic        s_ovr, s_perr, s_ferr, s_fl, tx_drv, tx_rcv;
  spf_ent_t    got_q[$];
  int          err_total = 0;
  int          compares = 0;
  int          low;
  spf_par_t    pars[5] = '{PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE};
  spf_stop_t   stps[5] = '{STOP_1, STOP_2, STOP_1P5, STOP_1, STOP_2};
  int          nbs[5]  = '{8, 7, 6, 5, 8};
  int          stc[5]  = '{DIV, 2 * DIV, DIV + DIV / 2, DIV, 2 * DIV};
  logic [7:0]  dats[5] = '{8'hA5, 8'h53, 8'hFB, 8'h00, 8'hFF};
  logic [7:0]  rxs[4]  = '{8'h41, 8'h0D, 8'h0A, 8'h5A};

  always #5 sys_clk = ~sys_clk;

  spf_serial_port #(.SEC_CYCLES(20), .PACK_BYTES(8)) spf_serial_port_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg(cfg), .pack(pack),
    .rxd(rxd), .txd(txd), .drv_en(drv_en), .rcv_en_n(rcv_en_n),
    .rts_out(rts_out), .dtr_out(dtr_out), .cts_in(cts_in), .dsr_in(dsr_in),
    .s2n_valid(s2n_valid), .s2n_ready(s2n_ready), .s2n_ent(s2n_ent),
    .n2s_valid(n2s_valid), .n2s_ready(n2s_ready), .n2s_data(n2s_data),
    .n2s_flush(n2s_flush), .stat(stat));

  spf_far_dev #(.DIV(DIV)) spf_far_dev_inst (
    .sys_clk(sys_clk), .txd(txd), .rxd(rxd), .cap_bits(cap_bits), .cap_cnt(cap_cnt));

  // collect taken words; latch one-cycle pulses so slow checks still see them
  always @(posedge sys_clk) begin
    if (s2n_valid && s2n_ready) got_q.push_back(s2n_ent);
    if (stat.overrun) s_ovr <= 1'b1;
    if (stat.parity_err) s_perr <= 1'b1;
    if (stat.frame_err) s_ferr <= 1'b1;
    if (n2s_flush) s_fl <= 1'b1;
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // expected line image, worked out independently of the design
  function automatic logic [11:0] frame(input logic [7:0] d, input int nb, input spf_par_t pm);
    logic [11:0] r;
    logic        p;
    r = '1;
    r[0] = 1'b0;
    p = ^(d & 8'((1 << nb) - 1));
    for (int i = 0; i < nb; i++) r[i + 1] = d[i];
    case (pm)
      PAR_ODD:   r[nb + 1] = ~p;
      PAR_EVEN:  r[nb + 1] = p;
      PAR_MARK:  r[nb + 1] = 1'b1;
      PAR_SPACE: r[nb + 1] = 1'b0;
      default:   ;
    endcase
    return r;
  endfunction : frame

  task automatic rst();
    sys_rst = 1'b1;
    got_q.delete();
    {s_ovr, s_perr, s_ferr, s_fl} = 4'h0;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
  endtask : rst

  // one byte into the transmitter; low counts cycles until ready again
  task automatic tx_byte(input logic [7:0] d);
    n2s_valid = 1'b1;
    n2s_data = d;
    low = 0;
    while (n2s_ready !== 1'b1) begin
      @(negedge sys_clk);
      low++;
      if (low > 9000) begin err_total++; final_report(); end
    end
    @(negedge sys_clk);
    n2s_valid = 1'b0;
    tx_drv = drv_en;
    tx_rcv = rcv_en_n;
    low = 0;
    while (n2s_ready !== 1'b1 && low < 9000) begin
      low++;
      @(negedge sys_clk);
    end
    // a character that never ends is a hang, not a slow pass
    if (low >= 9000) begin err_total++; final_report(); end
  endtask : tx_byte

  task automatic wait_cap(input logic [11:0] ex, input string nm);
    int n;
    n = 0;
    while (cap_cnt === c0) begin
      @(negedge sys_clk);
      n++;
      if (n > 9000) begin err_total++; final_report(); end
    end
    `CHK(nm, ex, cap_bits)
  endtask : wait_cap

  task automatic rx8(input logic [7:0] d);
    spf_far_dev_inst.send_raw(frame(d, 8, PAR_NONE));
  endtask : rx8

  initial begin : main
    cfg = '{baud_div: DIV_W'(DIV), par: PAR_NONE, data_bits: 2'h3, stop: STOP_1,
            flow: FLOW_NONE, ifc: IFC_232, perf_lat: 1'b0};
    pack = '0;
    // every parity mode, data size, stop length and line interface
    for (int k = 0; k < 5; k++) begin
      cfg.par = pars[k];
      cfg.data_bits = 2'(nbs[k] - 5);
      cfg.stop = stps[k];
      cfg.ifc = spf_ifc_t'(2'(k));
      rst();
      `CHK("drv_en idle", k < 2 || k == 4, drv_en)
      c0 = cap_cnt;
      tx_byte(dats[k]);
      `CHK("drv_en busy", 1'b1, tx_drv)
      `CHK("rcv_en_n busy", k == 2, tx_rcv)
      `CHK("char cycles", DIV * (1 + nbs[k] + (k > 0)) + stc[k], low)
      wait_cap(frame(dats[k], nbs[k], pars[k]), "tx frame");
    end
    // delimiter packing, consumer stalled until the buffer refuses
    cfg.par = PAR_NONE;
    cfg.stop = STOP_1;
    pack.s2n.val[0] = 8'h0D;
    pack.s2n.val[1] = 8'h0A;
    pack.s2n.cnt = 3'h2;
    s2n_ready = 1'b0;
    rst();
    foreach (rxs[i]) rx8(rxs[i]);
    `CHK("overrun", 1'b1, s_ovr)
    `CHK("stalled valid", 1'b1, s2n_valid)
    s2n_ready = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("packet size", 3, got_q.size())
    for (int i = 0; i < 3; i++) `CHK("packet word", {i == 2, rxs[i]}, got_q[i])
    // full packing buffer closes the packet; timeout off
    rst();
    for (int i = 0; i < 8; i++) rx8(8'(8'h30 + i));
    repeat (8) @(negedge sys_clk);
    `CHK("full size", 8, got_q.size())
    for (int i = 0; i < 8; i++) `CHK("full word", {i == 7, 8'(8'h30 + i)}, got_q[i])
    pack.flush_sec = 16'h0001;
    rst();
    rx8(8'h42);
    repeat (60) @(negedge sys_clk);
    `CHK("timeout word", {1'b1, 8'h42}, got_q[0])
    pack.flush_sec = 16'h0000;
    cfg.perf_lat = 1'b1;
    rst();
    rx8(8'h43);
    `CHK("latency word", {1'b1, 8'h43}, got_q[0])
    // bad parity keeps the byte, a low stop bit drops it
    cfg.par = PAR_EVEN;
    rst();
    f = frame(8'h07, 8, PAR_EVEN);
    f[9] = ~f[9];
    spf_far_dev_inst.send_raw(f);
    `CHK("parity error", 1'b1, s_perr)
    `CHK("parity kept", {1'b1, 8'h07}, got_q[0])
    f = frame(8'h08, 8, PAR_EVEN);
    f[10] = 1'b0;
    spf_far_dev_inst.send_raw(f);
    `CHK("frame error", 1'b1, s_ferr)
    `CHK("frame drop", 1, got_q.size())
    // software flow both ways
    cfg.par = PAR_NONE;
    cfg.flow = FLOW_XON;
    s2n_ready = 1'b0;
    rst();
    c0 = cap_cnt;
    rx8(8'h44);
    wait_cap(frame(XOFF_CHAR, 8, PAR_NONE), "xoff sent");
    c0 = cap_cnt;
    s2n_ready = 1'b1;
    wait_cap(frame(XON_CHAR, 8, PAR_NONE), "xon sent");
    rx8(XOFF_CHAR);
    `CHK("paused", 1'b1, stat.paused)
    `CHK("paused ready", 1'b0, n2s_ready)
    rx8(XON_CHAR);
    `CHK("resumed ready", 1'b1, n2s_ready)
    `CHK("flow chars eaten", 1, got_q.size())
    // hardware pairs; a stalled consumer drops the own ready line
    for (int m = 0; m < 2; m++) begin
      cfg.flow = m ? FLOW_DTR : FLOW_RTS;
      {cts_in, dsr_in} = 2'b00;
      s2n_ready = 1'b0;
      rst();
      `CHK("gate closed", 1'b0, n2s_ready)
      if (m) dsr_in = 1'b1;
      else cts_in = 1'b1;
      @(negedge sys_clk);
      `CHK("gate open", 1'b1, n2s_ready)
      rx8(8'h45);
      `CHK("rts level", m == 1, rts_out)
      `CHK("dtr level", m == 0, dtr_out)
    end
    // transmit side flush on delimiter, then by the forced interval
    cfg.flow = FLOW_NONE;
    s2n_ready = 1'b1;
    pack.n2s.val[0] = 8'h0D;
    pack.n2s.cnt = 3'h1;
    rst();
    tx_byte(8'h46);
    `CHK("no flush", 1'b0, s_fl)
    tx_byte(8'h0D);
    `CHK("delim flush", 1'b1, s_fl)
    pack.force_sec = 16'h0001;
    rst();
    tx_byte(8'h47);
    `CHK("forced flush", 1'b1, s_fl)
    final_report();
  end
endmodule : spf_serial_port_bench

`default_nettype wire
